// [rtl/asp_pkg.sv]
package asp_pkg;

  // register byte addresses on the wishbone slave
  localparam logic [31:0] ADR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADR_DIV = 32'h0000_0004;
  localparam logic [31:0] ADR_MOD = 32'h0000_0008;
  localparam logic [31:0] ADR_TXDATA = 32'h0000_000C;
  localparam logic [31:0] ADR_RXDATA = 32'h0000_0010;
  localparam logic [31:0] ADR_STATUS = 32'h0000_0014;
  localparam logic [31:0] ADR_MASK = 32'h0000_0018;

  // control register field positions
  localparam int CTL_SYNC = 0;
  localparam int CTL_CHAR8 = 1;
  localparam int CTL_PAREN = 2;
  localparam int CTL_PAREVEN = 3;
  localparam int CTL_TWOSTOP = 4;
  localparam int CTL_ADDRMODE = 5;
  localparam int CTL_TXADDR = 6;
  localparam int CTL_RXEN = 7;
  localparam int CTL_TXEN = 8;
  localparam int CTL_W = 9;

  // sticky status bits, same layout in the mask register; the two busy bits after them are live and not in the mask
  localparam int ST_RXDONE = 0;
  localparam int ST_TXDONE = 1;
  localparam int ST_PARERR = 2;
  localparam int ST_FRAMERR = 3;
  localparam int ST_OVERRUN = 4;
  localparam int ST_FALSESTART = 5;
  localparam int ST_W = 6;
  localparam int ST_TXBUSY = 8;
  localparam int ST_RXBUSY = 9;

  // reset values
  localparam logic [CTL_W-1:0] CTRL_RST = 9'h000;
  localparam logic [15:0] DIV_RST = 16'h0003;
  localparam logic [7:0] MOD_RST = 8'h00;
  localparam logic [ST_W-1:0] MASK_RST = 6'h00;

  // bit timing: smallest divisor, sample spacing as a right shift (1/32)
  localparam logic [15:0] DIV_MIN = 16'h0003;
  localparam int VOTE_SHIFT = 5;

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_ADDR, RX_STOP} asp_rx_state_type;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_ADDR, TX_STOP} asp_tx_state_type;

  // divisor as used by the timing logic, never below the minimum
  function automatic logic [15:0] asp_eff_div(input logic [15:0] d);
    asp_eff_div = (d < DIV_MIN) ? DIV_MIN : d;
  endfunction

endpackage

// [rtl/asp_timer_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface asp_timer_if;
  logic start;
  logic run;
  logic [15:0] divisor;
  logic [7:0] modPattern;
  logic [15:0] bitCount;
  logic bitEnd;
  modport timer(input start, input run, input divisor, input modPattern, output bitCount, output bitEnd);
  modport user(output start, output run, output divisor, output modPattern, input bitCount, input bitEnd);
  modport observer(input start, input run, input divisor, input bitCount);
endinterface
`default_nettype wire

// [rtl/asp_bit_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module asp_bit_timer (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // timing channel
  asp_timer_if.timer tmr
);

  typedef struct packed {
    logic [15:0] cnt;
    logic [2:0] idx;
  } asp_timer_state_type;

  asp_timer_state_type st_r;
  asp_timer_state_type st_nxt;
  logic [15:0] lastCnt;

  // prescaler plus modulator, restarted by each frame start
  always_comb
  begin
    st_nxt = st_r;
    lastCnt = package_last(tmr.divisor, tmr.modPattern[st_r.idx]);
    tmr.bitEnd = tmr.run & ~tmr.start & (st_r.cnt == lastCnt);
    if (!tmr.run || tmr.start)
    begin
      st_nxt.cnt = 16'h0000;
      st_nxt.idx = 3'h0;
    end
    else if (tmr.bitEnd)
    begin
      st_nxt.cnt = 16'h0000;
      st_nxt.idx = st_r.idx + 3'h1;
    end
    else
      st_nxt.cnt = st_r.cnt + 16'h0001;
  end

  assign tmr.bitCount = st_r.cnt;

  function automatic logic [15:0] package_last(input logic [15:0] d, input logic m);
    package_last = asp_pkg::asp_eff_div(d) - 16'h0001 + {15'h0000, m};
  endfunction

  // state register
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

endmodule
`default_nettype wire

// [rtl/asp_vote3.sv]
`timescale 1ns/1ps
`default_nettype none
module asp_vote3 (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // timing channel of the receiver
  asp_timer_if.observer tmr,
  // serial data and result
  input wire logic rxLine,
  output logic voteBit,
  output logic voteValid
);

  typedef struct packed {
    logic s0;
    logic s1;
    logic vote;
    logic valid;
  } asp_vote_state_type;

  asp_vote_state_type st_r;
  asp_vote_state_type st_nxt;
  logic [15:0] nEff;
  logic [15:0] half;
  logic [15:0] spread;

  // three samples around mid bit, result one cycle after the last
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.valid = 1'b0;
    nEff = asp_pkg::asp_eff_div(tmr.divisor);
    half = nEff >> 1;
    // spacing 1/32 of bit, at least one clock
    spread = nEff >> asp_pkg::VOTE_SHIFT;
    if (spread == 16'h0000)
      spread = 16'h0001;
    if (tmr.run && !tmr.start)
    begin
      if (tmr.bitCount == half - spread)
        st_nxt.s0 = rxLine;
      if (tmr.bitCount == half)
        st_nxt.s1 = rxLine;
      if (tmr.bitCount == half + spread)
      begin
        st_nxt.vote = (st_r.s0 & st_r.s1) | (st_r.s0 & rxLine) | (st_r.s1 & rxLine);
        st_nxt.valid = 1'b1;
      end
    end
  end

  assign voteBit = st_r.vote;
  assign voteValid = st_r.valid;

  // state register
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

endmodule
`default_nettype wire

// [rtl/asp_serial_port.sv]
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - sync bit set blocks new async frames; a frame already under way completes
// - data bits travel lsb first
// - start, data, parity, address, stop bits
// - falling edge, then two-of-three zero votes
// - samples at half bit minus, at, plus spread
// - spread is 1/32 of bit, minimum one
// - every bit decided by mid-bit majority
// - bit period from divisor and modulator registers
// - pattern lsb applies to start bit
// - pattern one adds one clock
// - pattern repeats after eight bits
// - receiver realigns on each start bit
// - independent sections, shared timing settings
module asp_serial_port (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // serial lines
  input wire logic serialInputLine,
  output logic serialOutputLine,
  // interrupt
  output logic irq
);

  typedef struct packed {
    logic ack;
    logic [31:0] datOut;
    logic [asp_pkg::CTL_W-1:0] ctrl;
    logic [15:0] div;
    logic [7:0] modp;
    logic [7:0] txData;
    logic [8:0] rxData;
    logic [asp_pkg::ST_W-1:0] status;
    logic [asp_pkg::ST_W-1:0] mask;
    asp_pkg::asp_rx_state_type rxState;
    logic rxPrev;
    logic [7:0] rxShift;
    logic [2:0] rxCnt;
    logic rxPar;
    logic rxAddr;
    asp_pkg::asp_tx_state_type txState;
    logic [7:0] txShift;
    logic [2:0] txCnt;
    logic txPar;
    logic txAddr;
    logic txStopMore;
    logic txLine;
  } asp_top_state_type;

  asp_top_state_type st_r;
  asp_top_state_type st_nxt;

  asp_timer_if txTmr();
  asp_timer_if rxTmr();

  logic voteBit;
  logic voteValid;
  logic req;
  logic wrEn;
  logic txGo;
  logic rxGo;
  logic txEnabled;
  logic rxEnabled;
  logic [2:0] lastBit;
  logic [31:0] readVal;
  logic [31:0] merged;
  logic [asp_pkg::ST_W-1:0] w1c;
  logic [asp_pkg::ST_W-1:0] events;
  logic [7:0] rxWord;
  logic [7:0] charMask;

  // two timers, one set of divisor and pattern
  asp_bit_timer txTimer (
    .core_clk(core_clk),
    .resetn(resetn),
    .tmr(txTmr)
  );

  asp_bit_timer rxTimer (
    .core_clk(core_clk),
    .resetn(resetn),
    .tmr(rxTmr)
  );

  asp_vote3 rxVote (
    .core_clk(core_clk),
    .resetn(resetn),
    .tmr(rxTmr),
    .rxLine(serialInputLine),
    .voteBit(voteBit),
    .voteValid(voteValid)
  );

  // byte-lane merge for partial writes
  function automatic logic [31:0] lane_merge(input logic [31:0] oldV, input logic [31:0] newV,
                                             input logic [3:0] sel);
    lane_merge = oldV;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        lane_merge[i*8 +: 8] = newV[i*8 +: 8];
    end
  endfunction

  assign txTmr.divisor = st_r.div;
  assign txTmr.modPattern = st_r.modp;
  assign rxTmr.divisor = st_r.div;
  assign rxTmr.modPattern = st_r.modp;
  assign txTmr.start = txGo;
  assign rxTmr.start = rxGo;
  assign txTmr.run = (st_r.txState != asp_pkg::TX_IDLE);
  assign rxTmr.run = (st_r.rxState != asp_pkg::RX_IDLE);

  // outputs straight from state flops, irq gated from the status and mask flops
  assign dat_o = st_r.datOut;
  assign ack_o = st_r.ack;
  assign serialOutputLine = st_r.txLine;
  assign irq = |(st_r.status & st_r.mask);

  // read multiplexer, unmapped addresses read zero
  always_comb
  begin
    readVal = 32'h0000_0000;
    unique case (adr_i)
      asp_pkg::ADR_CTRL: readVal[asp_pkg::CTL_W-1:0] = st_r.ctrl;
      asp_pkg::ADR_DIV: readVal[15:0] = st_r.div;
      asp_pkg::ADR_MOD: readVal[7:0] = st_r.modp;
      asp_pkg::ADR_TXDATA: readVal[7:0] = st_r.txData;
      asp_pkg::ADR_RXDATA: readVal[8:0] = st_r.rxData;
      asp_pkg::ADR_STATUS:
      begin
        readVal[asp_pkg::ST_W-1:0] = st_r.status;
        readVal[asp_pkg::ST_TXBUSY] = (st_r.txState != asp_pkg::TX_IDLE);
        readVal[asp_pkg::ST_RXBUSY] = (st_r.rxState != asp_pkg::RX_IDLE);
      end
      asp_pkg::ADR_MASK: readVal[asp_pkg::ST_W-1:0] = st_r.mask;
      default: readVal = 32'h0000_0000;
    endcase
  end

  // bus, transmitter and receiver next state
  always_comb
  begin
    st_nxt = st_r;
    events = '0;
    w1c = '0;
    txGo = 1'b0;
    rxGo = 1'b0;
    merged = 32'h0000_0000;
    rxWord = 8'h00;
    txEnabled = st_r.ctrl[asp_pkg::CTL_TXEN] & ~st_r.ctrl[asp_pkg::CTL_SYNC];
    rxEnabled = st_r.ctrl[asp_pkg::CTL_RXEN] & ~st_r.ctrl[asp_pkg::CTL_SYNC];
    lastBit = st_r.ctrl[asp_pkg::CTL_CHAR8] ? 3'h7 : 3'h6;
    charMask = st_r.ctrl[asp_pkg::CTL_CHAR8] ? 8'hFF : 8'h7F;

    // one wait state: ack in the cycle after the request is seen
    req = cyc_i & stb_i;
    st_nxt.ack = req & ~st_r.ack;
    if (req && !st_r.ack)
      st_nxt.datOut = readVal;
    wrEn = req & we_i & st_r.ack;
    if (wrEn)
    begin
      unique case (adr_i)
        asp_pkg::ADR_CTRL:
        begin
          merged = lane_merge({23'h000000, st_r.ctrl}, dat_i, sel_i);
          st_nxt.ctrl = merged[asp_pkg::CTL_W-1:0];
        end
        asp_pkg::ADR_DIV:
        begin
          merged = lane_merge({16'h0000, st_r.div}, dat_i, sel_i);
          st_nxt.div = merged[15:0];
        end
        asp_pkg::ADR_MOD:
        begin
          merged = lane_merge({24'h000000, st_r.modp}, dat_i, sel_i);
          st_nxt.modp = merged[7:0];
        end
        asp_pkg::ADR_MASK:
        begin
          merged = lane_merge({26'h0000000, st_r.mask}, dat_i, sel_i);
          st_nxt.mask = merged[asp_pkg::ST_W-1:0];
        end
        asp_pkg::ADR_STATUS: w1c = dat_i[asp_pkg::ST_W-1:0] & {asp_pkg::ST_W{sel_i[0]}};
        // a write while a frame is out is dropped; busy shows it
        asp_pkg::ADR_TXDATA: txGo = sel_i[0] & txEnabled & (st_r.txState == asp_pkg::TX_IDLE);
        default: merged = 32'h0000_0000;
      endcase
    end

    // transmitter: every change lands on a bit boundary of its timer
    unique case (st_r.txState)
      asp_pkg::TX_IDLE:
      begin
        st_nxt.txLine = 1'b1;
        if (txGo)
        begin
          st_nxt.txData = dat_i[7:0];
          st_nxt.txShift = dat_i[7:0] & charMask;
          st_nxt.txCnt = 3'h0;
          st_nxt.txPar = (^(dat_i[7:0] & charMask)) ^ ~st_r.ctrl[asp_pkg::CTL_PAREVEN];
          st_nxt.txAddr = st_r.ctrl[asp_pkg::CTL_TXADDR];
          st_nxt.txStopMore = st_r.ctrl[asp_pkg::CTL_TWOSTOP];
          st_nxt.txLine = 1'b0;
          st_nxt.txState = asp_pkg::TX_START;
        end
      end
      asp_pkg::TX_START, asp_pkg::TX_DATA:
      begin
        if (txTmr.bitEnd)
        begin
          if (st_r.txState == asp_pkg::TX_DATA && st_r.txCnt == lastBit)
          begin
            if (st_r.ctrl[asp_pkg::CTL_PAREN])
            begin
              st_nxt.txLine = st_r.txPar;
              st_nxt.txState = asp_pkg::TX_PARITY;
            end
            else if (st_r.ctrl[asp_pkg::CTL_ADDRMODE])
            begin
              st_nxt.txLine = st_r.txAddr;
              st_nxt.txState = asp_pkg::TX_ADDR;
            end
            else
            begin
              st_nxt.txLine = 1'b1;
              st_nxt.txState = asp_pkg::TX_STOP;
            end
          end
          else
          begin
            st_nxt.txLine = st_r.txShift[0];
            st_nxt.txShift = st_r.txShift >> 1;
            st_nxt.txCnt = (st_r.txState == asp_pkg::TX_DATA) ? st_r.txCnt + 3'h1 : 3'h0;
            st_nxt.txState = asp_pkg::TX_DATA;
          end
        end
      end
      asp_pkg::TX_PARITY:
      begin
        if (txTmr.bitEnd)
        begin
          st_nxt.txLine = st_r.ctrl[asp_pkg::CTL_ADDRMODE] ? st_r.txAddr : 1'b1;
          st_nxt.txState = st_r.ctrl[asp_pkg::CTL_ADDRMODE] ? asp_pkg::TX_ADDR : asp_pkg::TX_STOP;
        end
      end
      asp_pkg::TX_ADDR:
      begin
        if (txTmr.bitEnd)
        begin
          st_nxt.txLine = 1'b1;
          st_nxt.txState = asp_pkg::TX_STOP;
        end
      end
      asp_pkg::TX_STOP:
      begin
        // one or two high stop bits
        if (txTmr.bitEnd)
        begin
          if (st_r.txStopMore)
            st_nxt.txStopMore = 1'b0;
          else
          begin
            st_nxt.txState = asp_pkg::TX_IDLE;
            events[asp_pkg::ST_TXDONE] = 1'b1;
          end
        end
      end
      default: st_nxt.txState = asp_pkg::TX_IDLE;
    endcase

    // receiver: decisions taken on each mid-bit vote
    st_nxt.rxPrev = serialInputLine;
    unique case (st_r.rxState)
      asp_pkg::RX_IDLE:
      begin
        if (rxEnabled && st_r.rxPrev && !serialInputLine)
        begin
          rxGo = 1'b1;
          st_nxt.rxState = asp_pkg::RX_START;
        end
      end
      asp_pkg::RX_START:
      begin
        if (voteValid)
        begin
          st_nxt.rxCnt = 3'h0;
          st_nxt.rxState = voteBit ? asp_pkg::RX_IDLE : asp_pkg::RX_DATA;
          events[asp_pkg::ST_FALSESTART] = voteBit;
        end
      end
      asp_pkg::RX_DATA:
      begin
        if (voteValid)
        begin
          st_nxt.rxShift = {voteBit, st_r.rxShift[7:1]};
          st_nxt.rxCnt = st_r.rxCnt + 3'h1;
          if (st_r.rxCnt == lastBit)
          begin
            if (st_r.ctrl[asp_pkg::CTL_PAREN])
              st_nxt.rxState = asp_pkg::RX_PARITY;
            else if (st_r.ctrl[asp_pkg::CTL_ADDRMODE])
              st_nxt.rxState = asp_pkg::RX_ADDR;
            else
              st_nxt.rxState = asp_pkg::RX_STOP;
          end
        end
      end
      asp_pkg::RX_PARITY:
      begin
        if (voteValid)
        begin
          st_nxt.rxPar = voteBit;
          st_nxt.rxState = st_r.ctrl[asp_pkg::CTL_ADDRMODE] ? asp_pkg::RX_ADDR : asp_pkg::RX_STOP;
        end
      end
      asp_pkg::RX_ADDR:
      begin
        if (voteValid)
        begin
          st_nxt.rxAddr = voteBit;
          st_nxt.rxState = asp_pkg::RX_STOP;
        end
      end
      asp_pkg::RX_STOP:
      begin
        // returns idle at mid stop so a close next start is caught
        if (voteValid)
        begin
          rxWord = st_r.ctrl[asp_pkg::CTL_CHAR8] ? st_r.rxShift : {1'b0, st_r.rxShift[7:1]};
          st_nxt.rxData = {st_r.ctrl[asp_pkg::CTL_ADDRMODE] & st_r.rxAddr, rxWord};
          events[asp_pkg::ST_RXDONE] = 1'b1;
          events[asp_pkg::ST_OVERRUN] = st_r.status[asp_pkg::ST_RXDONE];
          events[asp_pkg::ST_FRAMERR] = ~voteBit;
          events[asp_pkg::ST_PARERR] = st_r.ctrl[asp_pkg::CTL_PAREN]
                                       & (st_r.rxPar != ((^rxWord) ^ ~st_r.ctrl[asp_pkg::CTL_PAREVEN]));
          st_nxt.rxState = asp_pkg::RX_IDLE;
        end
      end
      default: st_nxt.rxState = asp_pkg::RX_IDLE;
    endcase

    // sticky flags: a new event beats a same-cycle clear
    st_nxt.status = (st_r.status & ~w1c) | events;
  end

  // state register with documented reset values
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= '0;
      st_r.ctrl <= asp_pkg::CTRL_RST;
      st_r.div <= asp_pkg::DIV_RST;
      st_r.modp <= asp_pkg::MOD_RST;
      st_r.mask <= asp_pkg::MASK_RST;
      st_r.rxPrev <= 1'b1;
      st_r.txLine <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

endmodule
`default_nettype wire

// [dv/asp_serial_port_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module asp_serial_port_sva (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // serial lines and interrupt
  input wire logic serialInputLine,
  input wire logic serialOutputLine,
  input wire logic irq
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  // bus answers: one cycle late, one cycle long, only when asked
  chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
  chk_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i)) else $error("ack unasked");
  // reads past the map and upper halves of every register read zero
  chk_unmapped_zero: assert property (cyc_i && stb_i && !we_i && !ack_o && adr_i > asp_pkg::ADR_MASK
    |=> dat_o == 32'h0) else $error("unmapped read not zero");
  chk_upper_zero: assert property (ack_o && !we_i |-> dat_o[31:16] == 16'h0000) else $error("upper bits set");
  // irq only drops after a status clear or mask write lands
  chk_irq_clear: assert property ($fell(irq) |-> $past(ack_o && we_i)) else $error("irq dropped alone");
  // line leaves reset idle high
  chk_line_reset: assert property ($rose(resetn) |-> serialOutputLine) else $error("line not idle");
  // smallest divisor is 3, so no level may last under three clocks
  chk_bit_hold: assert property ($changed(serialOutputLine) |=> $stable(serialOutputLine) [*2])
    else $error("bit too short");

  // main scenarios
  cover property ($fell(serialOutputLine));
  cover property ($rose(irq));
  cover property (ack_o && we_i);
endmodule

bind asp_serial_port asp_serial_port_sva chk (.core_clk(core_clk), .resetn(resetn), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
  .serialInputLine(serialInputLine), .serialOutputLine(serialOutputLine), .irq(irq));
`default_nettype wire

// [dv/asp_remote_dev.sv]
`timescale 1ns/1ps
`default_nettype none
module asp_remote_dev (
  // clock
  input wire logic core_clk,
  // serial lines
  output logic lineOut,
  input wire logic lineIn
);
  int runQ[$];
  int runCnt = 0;
  logic lastLevel = 1'b1;

  initial lineOut = 1'b1;

  // run lengths of our receive side, in clocks; bit order and timing follow from them
  always @(posedge core_clk)
  begin
    if (lineIn !== lastLevel)
    begin
      runQ.push_back(runCnt);
      runCnt = 1;
      lastLevel = lineIn;
    end
    else
      runCnt++;
  end

  task automatic send(input logic [15:0] bits, input int cnt, input int div, input logic [7:0] pat);
    for (int k = 0; k < cnt; k++)
    begin
      lineOut <= bits[k];
      repeat (div + pat[k % 8]) @(posedge core_clk);
    end
    lineOut <= 1'b1;
  endtask
endmodule
`default_nettype wire

// [dv/asp_serial_port_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module asp_serial_port_tb_top;
  localparam int DIV = 8;
  logic coreClk = 1'b0;
  logic resetn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [31:0] adr = 32'h0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] rdat;
  logic ack;
  logic rxLine;
  logic txLine;
  logic irq;
  logic [31:0] rd;
  logic [15:0] fBits;
  int fCnt;
  int err_total = 0;
  int check_count = 0;
  // frame formats: bits, parity, even, stops, address mode
  int cBits[3] = '{8, 7, 8};
  int cPar[3] = '{0, 1, 1};
  int cEven[3] = '{0, 1, 0};
  int cStop[3] = '{1, 2, 1};
  int cAdr[3] = '{0, 0, 1};
  logic [7:0] cPat[3] = '{8'h6F, 8'hD5, 8'h01};
  logic [7:0] cData[3] = '{8'h55, 8'h2D, 8'hC3};
  logic [31:0] rAdr[6] = '{asp_pkg::ADR_CTRL, asp_pkg::ADR_DIV, asp_pkg::ADR_MOD, asp_pkg::ADR_MASK,
    asp_pkg::ADR_STATUS, 32'h0000_0100};
  logic [31:0] rExp[6] = '{32'h0, 32'h3, 32'h0, 32'h0, 32'h0, 32'h0};

  // design and its remote partner
  asp_serial_port dut (.core_clk(coreClk), .resetn(resetn), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .dat_i(wdat), .sel_i(sel), .dat_o(rdat), .ack_o(ack), .serialInputLine(rxLine), .serialOutputLine(txLine),
    .irq(irq));
  asp_remote_dev peer (.core_clk(coreClk), .lineOut(rxLine), .lineIn(txLine));

  // free running clock
  always #25 coreClk = ~coreClk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // classic cycle held until ack; ends at negedge so outputs have settled
  // no cycle count assumed here: only the watchdog ends a wait for ack
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge coreClk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do
    begin
      @(posedge coreClk);
    end
    while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(negedge coreClk);
    check(ack, 32'h0, "ack drop");
  endtask

  // poll status until a flag sets, bounded
  task automatic wait_st(input int b);
    int n = 0;
    do
    begin
      wb(1'b0, asp_pkg::ADR_STATUS, 32'h0);
      n++;
    end
    while (rd[b] !== 1'b1 && n < 400);
    // a flag that never sets ends the run as a failure
    if (rd[b] !== 1'b1)
    begin
      err_total++;
      $display("mismatch at %0t: status flag %0d never set", $time, b);
      results();
    end
  endtask

  // line image of one frame, start bit first
  task automatic mk(input logic [7:0] d, input int c);
    fBits = 16'h0;
    fCnt = 1;
    for (int k = 0; k < cBits[c]; k++)
      fBits[fCnt++] = d[k];
    if (cPar[c] != 0)
      fBits[fCnt++] = (^d) ^ (cEven[c] == 0);
    if (cAdr[c] != 0)
      fBits[fCnt++] = 1'b1;
    repeat (cStop[c]) fBits[fCnt++] = 1'b1;
  endtask

  function automatic logic [31:0] ctl(input int c);
    return (32'(cBits[c] == 8) << asp_pkg::CTL_CHAR8) | (32'(cPar[c]) << asp_pkg::CTL_PAREN)
      | (32'(cEven[c]) << asp_pkg::CTL_PAREVEN) | (32'(cStop[c] == 2) << asp_pkg::CTL_TWOSTOP)
      | (32'(cAdr[c]) << asp_pkg::CTL_ADDRMODE) | (32'(cAdr[c]) << asp_pkg::CTL_TXADDR)
      | (32'h1 << asp_pkg::CTL_RXEN) | (32'h1 << asp_pkg::CTL_TXEN);
  endfunction

  task automatic t_regs();
    foreach (rAdr[i])
    begin
      wb(1'b0, rAdr[i], 32'h0);
      check(rd, rExp[i], "reset value");
    end
    wb(1'b1, 32'h0000_0100, 32'hFFFF_FFFF);
    wb(1'b0, 32'h0000_0100, 32'h0);
    check(rd, 32'h0, "unmapped");
  endtask

  // sync mode set: a transmit write must not start a frame
  task automatic t_sync();
    wb(1'b1, asp_pkg::ADR_CTRL, (32'h1 << asp_pkg::CTL_SYNC) | (32'h1 << asp_pkg::CTL_TXEN));
    peer.runQ.delete();
    wb(1'b1, asp_pkg::ADR_TXDATA, 32'h0000_0055);
    wb(1'b0, asp_pkg::ADR_STATUS, 32'h0);
    check(rd[asp_pkg::ST_TXBUSY], 32'h0, "sync busy");
    check(peer.runQ.size(), 32'h0, "sync line");
  endtask

  // every run on the line against the modulated bit lengths
  task automatic t_tx(input int c);
    int exp[$];
    int len = 0;
    mk(cData[c], c);
    peer.runQ.delete();
    wb(1'b1, asp_pkg::ADR_TXDATA, {24'h0, cData[c]});
    wait_st(asp_pkg::ST_TXDONE);
    check(rd[asp_pkg::ST_TXDONE], 32'h1, "tx done");
    for (int k = 0; k < fCnt; k++)
    begin
      len += DIV + cPat[c][k % 8];
      if (k == fCnt - 1 || fBits[k + 1] != fBits[k])
      begin
        exp.push_back(len);
        len = 0;
      end
    end
    // last run runs on into idle and is never closed
    void'(exp.pop_back());
    check(peer.runQ.size(), exp.size() + 1, "run count");
    foreach (exp[i]) check(peer.runQ[i + 1], exp[i], "bit run");
  endtask

  task automatic t_rx(input int c, input logic bad);
    mk(cData[c], c);
    if (bad)
      fBits[cBits[c] + 1] = ~fBits[cBits[c] + 1];
    @(posedge coreClk);
    peer.send(fBits, fCnt, DIV, cPat[c]);
    wait_st(asp_pkg::ST_RXDONE);
    check(rd[asp_pkg::ST_PARERR], {31'h0, bad}, "parity flag");
    check(rd[asp_pkg::ST_FRAMERR], 32'h0, "frame flag");
    wb(1'b0, asp_pkg::ADR_RXDATA, 32'h0);
    check(rd[8:0], {cAdr[c][0], cData[c]}, "rx data");
    wb(1'b1, asp_pkg::ADR_STATUS, 32'h0000_003F);
  endtask

  // a 3 clock low pulse misses all votes, a 7 clock one wins all three
  task automatic t_start();
    for (int i = 0; i < 2; i++)
    begin
      wb(1'b1, asp_pkg::ADR_STATUS, 32'h0000_003F);
      @(posedge coreClk);
      peer.send(16'h0, 1, (i == 0) ? 3 : 7, 8'h00);
      wait_st((i == 0) ? asp_pkg::ST_FALSESTART : asp_pkg::ST_RXDONE);
      check(rd[asp_pkg::ST_FALSESTART], 32'(i == 0), "false start");
      check(rd[asp_pkg::ST_RXDONE], 32'(i == 1), "start taken");
    end
  endtask

  // rxDone is left set: masked, unmasked, then cleared
  task automatic t_irq();
    check(irq, 32'h0, "irq masked");
    wb(1'b1, asp_pkg::ADR_MASK, 32'h1 << asp_pkg::ST_RXDONE);
    check(irq, 32'h1, "irq raised");
    wb(1'b1, asp_pkg::ADR_STATUS, 32'h1 << asp_pkg::ST_RXDONE);
    check(irq, 32'h0, "irq cleared");
    wb(1'b0, asp_pkg::ADR_STATUS, 32'h0);
    check(rd[asp_pkg::ST_RXDONE], 32'h0, "status cleared");
  endtask

  // main sequence
  initial
  begin
    repeat (3) @(posedge coreClk);
    resetn <= 1'b1;
    t_regs();
    t_sync();
    wb(1'b1, asp_pkg::ADR_DIV, DIV);
    for (int c = 0; c < 3; c++)
    begin
      wb(1'b1, asp_pkg::ADR_CTRL, ctl(c));
      wb(1'b1, asp_pkg::ADR_MOD, {24'h0, cPat[c]});
      t_tx(c);
      t_rx(c, 1'b0);
    end
    t_rx(2, 1'b1);
    t_start();
    t_irq();
    results();
  end

  // watchdog: the run needs well under 20000 clocks
  initial
  begin
    #1000000;
    err_total++;
    $display("mismatch at %0t: watchdog ran out", $time);
    results();
  end
endmodule
`default_nettype wire
